// ==== verilog/ad_demux_pkg.sv ====
// package for the split bus address/data front end
// shared widths, strap encodings and the carrier structs of the user side
package ad_demux_pkg;

  localparam int AD_W = 8;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // strobe-select strap meanings
  localparam logic STRAP_LATCH = 1'b0;
  localparam logic STRAP_IND = 1'b1;
  // indicator meanings
  localparam logic IND_DATA = 1'b0;
  localparam logic IND_ADDR = 1'b1;

  // power-up capture sequence
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_RUN = 2'b01
  } strap_state_t;

  // one accepted bus write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } bus_write_t;

endpackage

// ==== verilog/split_bus_addr_data_demux.sv ====
// split bus address/data demultiplexer for the host port
// assumes host strobes are synchronous to clk_sys_in and straps settle by reset release
// Function
// - one 8-bit shared bus carries address then data at different times.
// - strobe-select strap is caught once after reset and fixes address marking.
// - strap low means latch strobe; strap high means address/data indicator.
// - latch mode: each latch falling edge captures the bus as address.
// - indicator mode: indicator sampled at write strobe rising edge.
// - indicator high at that edge: bus value is a register address.
// - indicator low at that edge: bus value is register data.
// - bus-style strap is only captured and shown on split_mode_out; strobe decoding ignores it.
`timescale 1ns/100ps
module split_bus_addr_data_demux
  import ad_demux_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // straps
  input wire logic strobe_select_strap_in,
  input wire logic bus_style_strap_in,
  // host bus pins
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe_out,
  input wire logic latch_or_select_input_in,
  input wire logic wr_n_in,
  // user side
  output bus_write_t wr_out,
  output logic wr_valid_out,
  output logic [7:0] addr_out,
  output logic addr_valid_out,
  output logic ind_mode_out,
  output logic split_mode_out
);

  // strap capture state
  strap_state_t state_ff, nxt_state;
  logic ind_mode_ff, nxt_ind_mode;
  logic split_ff, nxt_split;
  // strobe history
  logic las_ff, nxt_las;
  logic wr_n_ff, nxt_wr_n;
  // held address
  logic [7:0] addr_ff, nxt_addr;
  logic addr_valid_ff, nxt_addr_valid;
  // last data write
  bus_write_t wr_ff, nxt_wr;
  logic wr_valid_ff, nxt_wr_valid;
  // decode of the current edge
  logic run;
  logic las_fall, wr_rise;
  logic ind_high;
  logic latch_addr, ind_addr;
  logic take_addr, take_data;
  logic [7:0] bus_addr, bus_data;

  // strap capture: straps are read once, on the first edge after reset
  always_comb begin
    nxt_state = state_ff;
    nxt_ind_mode = ind_mode_ff;
    nxt_split = split_ff;
    case (state_ff)
      ST_CAPTURE: begin
        nxt_ind_mode = (strobe_select_strap_in == STRAP_IND);
        nxt_split = bus_style_strap_in;
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        // mode stays fixed until the next reset
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_CAPTURE;
      end
    endcase
  end

  // strap capture registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_CAPTURE;
      ind_mode_ff <= STRAP_IND;
      split_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ind_mode_ff <= nxt_ind_mode;
      split_ff <= nxt_split;
    end
  end

  // strobes count only once the mode is fixed
  assign run = (state_ff == ST_RUN);

  // strobe history: previous level of both host strobes
  always_comb begin
    nxt_las = latch_or_select_input_in;
    nxt_wr_n = wr_n_in;
  end

  // strobe history registers; idle levels avoid a false edge after reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      las_ff <= 1'b0;
      wr_n_ff <= 1'b1;
    end else begin
      las_ff <= nxt_las;
      wr_n_ff <= nxt_wr_n;
    end
  end

  // edge detection on the host strobes
  assign las_fall = las_ff & ~latch_or_select_input_in;
  assign wr_rise = ~wr_n_ff & wr_n_in;

  // indicator level taken at the same edge as the write strobe rise
  assign ind_high = (latch_or_select_input_in == IND_ADDR);

  // address phase in each marking method
  assign latch_addr = ~ind_mode_ff & las_fall;
  assign ind_addr = ind_mode_ff & wr_rise & ind_high;

  // classify the bus contents of this edge; latch mode treats every write as data
  assign take_addr = run & (latch_addr | ind_addr);
  assign take_data = run & wr_rise & ~(ind_mode_ff & ind_high);

  // per-lane steering of the shared bus into address and data
  for (genvar b = 0; b < AD_W; b++) begin : g_lane
    assign bus_addr[b] = take_addr ? ad_in[b] : addr_ff[b];
    assign bus_data[b] = take_data ? ad_in[b] : wr_ff.data[b];
  end

  // held address: kept until the next address phase
  always_comb begin
    nxt_addr = bus_addr;
    nxt_addr_valid = addr_valid_ff | take_addr;
  end

  // held address registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      addr_ff <= ADDR_RST;
      addr_valid_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      addr_valid_ff <= nxt_addr_valid;
    end
  end

  // data write: paired with the address held before this edge
  always_comb begin
    nxt_wr = wr_ff;
    nxt_wr_valid = take_data;
    if (take_data) begin
      nxt_wr.addr = addr_ff;
    end
    nxt_wr.data = bus_data;
  end

  // data write registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ff <= '{addr: ADDR_RST, data: DATA_RST};
      wr_valid_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      wr_valid_ff <= nxt_wr_valid;
    end
  end

  // outputs; read path is outside this block so the bus is never driven
  assign ad_out = DATA_RST;
  assign ad_oe_out = 1'b0;
  assign wr_out = wr_ff;
  assign wr_valid_out = wr_valid_ff;
  assign addr_out = addr_ff;
  assign addr_valid_out = addr_valid_ff;
  assign ind_mode_out = ind_mode_ff;
  assign split_mode_out = split_ff;

endmodule

// ==== tb/split_bus_demux_sva.sv ====
// checker for the split bus demux
// assumes host strobes are synchronous to clk_sys_in
`timescale 1ns/100ps
module split_bus_demux_sva
  import ad_demux_pkg::*;
(
  input wire logic clk_sys_in, rst_n_in, strobe_select_strap_in, bus_style_strap_in,
  input wire logic [7:0] ad_in, addr_out,
  input wire logic ad_oe_out, latch_or_select_input_in, wr_n_in, wr_valid_out,
  input wire logic ind_mode_out, split_mode_out, addr_valid_out,
  input wire bus_write_t wr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // capture, hold and mode relations
  a_bus_idle: assert property (!ad_oe_out) else $error("bus driven");
  a_latch_addr: assert property (!ind_mode_out && $fell(latch_or_select_input_in)
    |=> addr_out == $past(ad_in)) else $error("latch addr");
  a_ind_addr: assert property (ind_mode_out && $rose(wr_n_in) && latch_or_select_input_in
    |=> addr_out == $past(ad_in)) else $error("ind addr");
  a_data_write: assert property ($rose(wr_n_in) && !(ind_mode_out && latch_or_select_input_in)
    |=> wr_valid_out && wr_out.data == $past(ad_in)) else $error("data write");
  a_ind_hold: assert property (ind_mode_out && !$rose(wr_n_in)
    |=> $stable(addr_out)) else $error("addr moved");
  a_pair_addr: assert property (wr_valid_out |-> wr_out.addr == $past(addr_out))
    else $error("pair addr");
  a_mode_fix: assert property ($rose(rst_n_in)
    |=> ind_mode_out == $past(strobe_select_strap_in) ##1 $stable(ind_mode_out)) else $error("mode");
  a_split_mode: assert property ($rose(rst_n_in)
    |=> split_mode_out == $past(bus_style_strap_in)) else $error("split mode");
  a_valid_hold: assert property (addr_valid_out |=> addr_valid_out)
    else $error("valid dropped");
  // main scenarios
  c_ind_wr: cover property (wr_valid_out && ind_mode_out);
  c_latch_addr: cover property (!ind_mode_out && $fell(latch_or_select_input_in));
  c_latch_wr: cover property (wr_valid_out && !ind_mode_out);
  c_ind_latch: cover property (ind_mode_out && $fell(latch_or_select_input_in));
endmodule
bind split_bus_addr_data_demux split_bus_demux_sva i_sva (.*);

// ==== tb/host_bus_model.sv ====
// host side model: latch strobes and write strobes on the shared bus
// assumes the bench calls xfer; released bus shows the inverse value
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clk_sys_in,
  output logic [7:0] ad_out = 8'h00,
  output logic sel_out = 1'b0,
  output logic wr_n_out = 1'b1
);
  // one transfer, bus held through the taking edge
  task automatic xfer(input logic lat, input logic ind, input logic [7:0] v);
    @(posedge clk_sys_in) begin ad_out <= v; sel_out <= lat | ind; wr_n_out <= lat; end
    @(posedge clk_sys_in) begin sel_out <= ind & ~lat; wr_n_out <= 1'b1; end
    @(posedge clk_sys_in) begin ad_out <= ~v; sel_out <= 1'b0; end
  endtask
endmodule

// ==== tb/split_bus_addr_data_demux_tb.sv ====
// bench: table of host transfers in both strap modes
// assumes host_bus_model on the pins and the bound checker
`timescale 1ns/100ps
module split_bus_addr_data_demux_tb;
  import ad_demux_pkg::*;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, strap = 1'b0, sel, wr_n, wrv, indm, splm, addrv;
  logic [7:0] ad, addr;
  bus_write_t wr;
  int bad_count = 0, check_count = 0, cyc = 0;
  // {strap, latch, indicator, bus value, expected address}
  logic [18:0] rows [8] = '{{3'b010, 8'h3c, 8'h3c}, {3'b000, 8'h5a, 8'h3c},
    {3'b010, 8'hff, 8'hff}, {3'b000, 8'h00, 8'hff}, {3'b101, 8'ha5, 8'ha5},
    {3'b100, 8'hc3, 8'ha5}, {3'b100, 8'h0f, 8'ha5}, {3'b110, 8'h77, 8'ha5}};
  host_bus_model i_host (.clk_sys_in(clk_sys_in), .ad_out(ad), .sel_out(sel), .wr_n_out(wr_n));
  split_bus_addr_data_demux i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .strobe_select_strap_in(strap), .bus_style_strap_in(1'b1), .ad_in(ad), .ad_out(),
    .ad_oe_out(), .latch_or_select_input_in(sel), .wr_n_in(wr_n), .wr_out(wr),
    .wr_valid_out(wrv), .addr_out(addr), .addr_valid_out(addrv), .ind_mode_out(indm),
    .split_mode_out(splm));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reset with a new strap, then mode check after capture
  task automatic do_reset(input logic s);
    @(posedge clk_sys_in) begin rst_n_in <= 1'b0; strap <= s; end
    repeat (10) @(posedge clk_sys_in);
    #1 chk("reset", 16'h0000, {6'h00, addrv, wrv, addr});
    @(posedge clk_sys_in) rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 chk("mode", {14'h0, s, 1'b1}, {14'h0, indm, splm});
  endtask
  // cycle ceiling
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin bad_count++; results(); end
  end
  // table loop, strap change forces a mid-run reset
  initial begin
    logic s, l, n, w;
    logic [7:0] v, ea;
    for (int i = 0; i < 8; i++) begin
      {s, l, n, v, ea} = rows[i];
      if (i == 0 || s !== strap) do_reset(s);
      i_host.xfer(l, n, v);
      #1;
      w = !l && !(s && n);
      chk("addr", {6'h00, 1'b1, w, ea}, {6'h00, addrv, wrv, addr});
      if (w) chk("write", {ea, v}, wr);
      $display("test %0d done", i);
    end
    results();
  end
endmodule
